// ### atc_pkg.sv
// Purpose: shared constants for the asynchronous 8-bit timer with one compare channel
// Assumes: 50 MHz system clock, byte-wide register port
// Notes: register indices are those of the plain register port
package atc_pkg;
    // register port indices
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_COUNTER = 3'h1;
    localparam logic [2:0] ADDR_COMPARE = 3'h2;
    localparam logic [2:0] ADDR_ASYNC = 3'h3;
    localparam logic [2:0] ADDR_FLAGS = 3'h4;

    // timer_control fields
    localparam int CTL_FORCE = 7;
    localparam int CTL_WAVE0 = 6;
    localparam int CTL_COM_HI = 5;
    localparam int CTL_COM_LO = 4;
    localparam int CTL_WAVE1 = 3;
    localparam int CTL_CS_HI = 2;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // async_status fields
    localparam int AS_EXT_CLK = 4;
    localparam int AS_ASYNC = 3;
    localparam int AS_CNT_BUSY = 2;
    localparam int AS_CMP_BUSY = 1;
    localparam int AS_CTL_BUSY = 0;

    // flag register fields
    localparam int FL_COMPARE = 1;
    localparam int FL_OVERFLOW = 0;

    // busy slots for the three buffered registers
    localparam int SLOT_CTL = 0;
    localparam int SLOT_CMP = 1;
    localparam int SLOT_CNT = 2;
    localparam int SLOTS = 3;
    // oscillator edges before a buffered value lands
    localparam logic [1:0] XFER_EDGES = 2'h2;

    // waveform modes
    localparam logic [1:0] WAVE_NORMAL = 2'h0;
    localparam logic [1:0] WAVE_PHASE = 2'h1;
    localparam logic [1:0] WAVE_CTC = 2'h2;
    localparam logic [1:0] WAVE_FAST = 2'h3;

    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;

    // prescaler masks: tick when the divide counter's masked bits are all ones
    localparam logic [9:0] DIV_MASK_1 = 10'h000;
    localparam logic [9:0] DIV_MASK_8 = 10'h007;
    localparam logic [9:0] DIV_MASK_32 = 10'h01f;
    localparam logic [9:0] DIV_MASK_64 = 10'h03f;
    localparam logic [9:0] DIV_MASK_128 = 10'h07f;
    localparam logic [9:0] DIV_MASK_256 = 10'h0ff;
    localparam logic [9:0] DIV_MASK_1024 = 10'h3ff;
endpackage

// ### atc_prescaler.sv
// Purpose: divides the timer source tick into the selected timer clock enable
// Assumes: src_tick is a one-cycle enable on clk_sys
// Notes: divider runs free while any source is ticking
module atc_prescaler (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic src_tick,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [9:0] div;
    logic [9:0] next_div;
    logic [9:0] mask;

    // mask per clock select value, 000 stops the timer
    always_comb begin
        case (sel)
            3'h1: mask = atc_pkg::DIV_MASK_1;
            3'h2: mask = atc_pkg::DIV_MASK_8;
            3'h3: mask = atc_pkg::DIV_MASK_32;
            3'h4: mask = atc_pkg::DIV_MASK_64;
            3'h5: mask = atc_pkg::DIV_MASK_128;
            3'h6: mask = atc_pkg::DIV_MASK_256;
            default: mask = atc_pkg::DIV_MASK_1024;
        endcase
        next_div = src_tick ? div + 10'h001 : div;
        tick = src_tick && (sel != 3'h0) && ((div & mask) == mask); // R6
    end

    // divide counter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div <= 10'h000;
        end else begin
            div <= next_div;
        end
    end
endmodule

// ### atc_timer.sv
// Purpose: 8-bit timer with one compare channel, sync or oscillator-pin clocking
// Assumes: single clk_sys domain, oscillator pin sampled as a plain input
// Notes: register reads answer one cycle after the read strobe
// Overview of operation
// R1 - nonzero output mode: pin shows compare output, driver per direction
// R2 - non-PWM modes: off, toggle, clear, set on match
// R3 - fast PWM: 10 clear on match, set at bottom; 11 inverse
// R4 - PWM, compare at TOP, upper bit: act at TOP
// R5 - phase correct: 10 clear up, set down; 11 inverse
// R6 - clock select 000 stops, else divide 1 to 1024
// R7 - counter readable and writable directly
// R8 - counter write hides next timer clock's match
// R9 - compare always checked; match sets flag, drives output
// R10 - ext clock enable picks input buffer, else crystal
// R11 - software sets ext clock enable before async select
// R12 - async select 0 system clock, 1 oscillator pin
// R13 - software rewrites registers after async select change
// R14 - async counter write busy until loaded
// R15 - async compare write busy until loaded
// R16 - async control write busy until loaded
// R17 - no write while own busy flag set
// R18 - counter reads live, compare and control temporaries
// R19 - buffered value lands after two oscillator edges
// R20 - compare flag set on match, cleared by ack or one
// R21 - waveform mode: normal, phase PWM, clear-on-match, fast PWM
//
// The register offsets and the plain strobed port were decided locally.
module atc_timer (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic timer_osc_in,
    input wire logic vector_ack,
    input wire logic port_out,
    input wire logic port_dir,
    output logic pin_out,
    output logic pin_oe_n,
    output logic compare_output_pin,
    output logic compare_flag,
    output logic overflow_flag,
    output logic ext_clock_buf_en,
    output logic crystal_osc_en
);
    // oscillator pin synchroniser and filtered level
    logic osc_s1, osc_s2, osc_s3, osc_lvl;
    logic next_osc_lvl, osc_rise;

    // software-facing copies and live registers
    logic [7:0] ctl_tmp, cmp_tmp, cnt_tmp;
    logic [7:0] next_ctl_tmp, next_cmp_tmp, next_cnt_tmp;
    logic [7:0] ctl_act, cmp_act, counter_value;
    logic [7:0] next_ctl_act, next_cmp_act, next_counter_value;
    logic ext_clock_enable, async_clock_select;
    logic next_ext_clock_enable, next_async_clock_select;
    localparam int SLOTS_W = atc_pkg::SLOTS;
    logic [SLOTS_W-1:0] busy, next_busy, xfer;
    logic [1:0] edges [SLOTS_W];
    logic [1:0] next_edges [SLOTS_W];


    // timer state
    logic count_down, next_count_down;
    logic match_block, next_match_block;
    logic oc, next_oc;
    logic next_compare_flag, next_overflow_flag;
    logic [7:0] next_rdata;

    logic src_tick, timer_tick;
    logic [1:0] wave;
    logic [1:0] com;
    logic pwm, at_top, match;
    logic [7:0] top;
    logic wr_ctl, wr_cmp, wr_cnt, wr_async, wr_flags;

    // three-flop sampling; stages two and three must agree
    always_comb begin
        next_osc_lvl = (osc_s2 == osc_s3) ? osc_s3 : osc_lvl;
        osc_rise = (osc_s2 == osc_s3) && osc_s3 && !osc_lvl;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
            osc_lvl <= 1'b0;
        end else begin
            osc_s1 <= timer_osc_in;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            osc_lvl <= next_osc_lvl;
        end
    end

    // source clock: every system cycle, or each filtered oscillator rising edge
    assign src_tick = async_clock_select ? osc_rise : 1'b1; // R12

    atc_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .rst(rst),
        .src_tick(src_tick),
        .sel(ctl_act[atc_pkg::CTL_CS_HI:0]),
        .tick(timer_tick)
    );

    // write decode
    assign wr_ctl = reg_wr && (reg_addr == atc_pkg::ADDR_CONTROL);
    assign wr_cmp = reg_wr && (reg_addr == atc_pkg::ADDR_COMPARE);
    assign wr_cnt = reg_wr && (reg_addr == atc_pkg::ADDR_COUNTER);
    assign wr_async = reg_wr && (reg_addr == atc_pkg::ADDR_ASYNC);
    assign wr_flags = reg_wr && (reg_addr == atc_pkg::ADDR_FLAGS);

    // busy per buffered register; transfer on the second edge
    always_comb begin
        logic [SLOTS_W-1:0] wr_slot;
        wr_slot = '0;
        wr_slot[atc_pkg::SLOT_CTL] = wr_ctl;
        wr_slot[atc_pkg::SLOT_CMP] = wr_cmp;
        wr_slot[atc_pkg::SLOT_CNT] = wr_cnt;
        for (int i = 0; i < SLOTS_W; i++) begin
            xfer[i] = busy[i] && osc_rise && (edges[i] == atc_pkg::XFER_EDGES - 2'h1); // R19
            next_busy[i] = busy[i];
            next_edges[i] = edges[i];
            if (xfer[i]) begin
                next_busy[i] = 1'b0; // R14 R15 R16
                next_edges[i] = 2'h0;
            end else if (busy[i] && osc_rise) begin
                next_edges[i] = edges[i] + 2'h1;
            end
            // a write restarts the wait
            if (wr_slot[i] && async_clock_select) begin
                next_busy[i] = 1'b1; // R14 R15 R16
                next_edges[i] = 2'h0;
            end
        end
    end

    // temporaries take every write so control and compare reads see it at once
    always_comb begin
        next_ctl_tmp = ctl_tmp;
        next_cmp_tmp = cmp_tmp;
        next_cnt_tmp = cnt_tmp;
        next_ext_clock_enable = ext_clock_enable;
        next_async_clock_select = async_clock_select;
        if (wr_ctl) begin
            next_ctl_tmp = {1'b0, reg_wdata[6:0]}; // force bit never stored
        end
        if (wr_cmp) begin
            next_cmp_tmp = reg_wdata;
        end
        if (wr_cnt) begin
            next_cnt_tmp = reg_wdata;
        end
        if (wr_async) begin
            next_ext_clock_enable = reg_wdata[atc_pkg::AS_EXT_CLK];
            next_async_clock_select = reg_wdata[atc_pkg::AS_ASYNC];
        end
    end

    // oscillator pin controls
    assign ext_clock_buf_en = async_clock_select && ext_clock_enable; // R10
    assign crystal_osc_en = async_clock_select && !ext_clock_enable; // R10

    // mode decode from the live control copy
    assign wave = {ctl_act[atc_pkg::CTL_WAVE1], ctl_act[atc_pkg::CTL_WAVE0]}; // R21
    assign com = ctl_act[atc_pkg::CTL_COM_HI:atc_pkg::CTL_COM_LO];
    assign pwm = (wave == atc_pkg::WAVE_PHASE) || (wave == atc_pkg::WAVE_FAST);
    assign top = (wave == atc_pkg::WAVE_CTC) ? cmp_act : atc_pkg::CNT_MAX; // R21
    assign at_top = (counter_value == top);
    // a fresh counter write blocks one timer clock
    assign match = (counter_value == cmp_act) && !match_block; // R9 R8

    // counter, direction, live registers and waveform output
    always_comb begin
        logic do_match, force_cmp;
        do_match = 1'b0;
        force_cmp = 1'b0;
        next_counter_value = counter_value;
        next_count_down = count_down;
        next_match_block = match_block;
        next_oc = oc;
        next_overflow_flag = overflow_flag;
        next_ctl_act = ctl_act;
        next_cmp_act = cmp_act;

        if (timer_tick) begin
            next_match_block = 1'b0;
            do_match = match;
            case (wave)
                atc_pkg::WAVE_PHASE: begin
                    // dual slope: turn at MAX and at BOTTOM, overflow at BOTTOM
                    if (!count_down) begin
                        if (counter_value == atc_pkg::CNT_MAX) begin
                            next_count_down = 1'b1;
                            next_counter_value = counter_value - 8'h01;
                        end else begin
                            next_counter_value = counter_value + 8'h01;
                        end
                    end else if (counter_value == atc_pkg::CNT_BOTTOM) begin
                        next_count_down = 1'b0;
                        next_counter_value = counter_value + 8'h01;
                        next_overflow_flag = 1'b1;
                    end else begin
                        next_counter_value = counter_value - 8'h01;
                    end
                end
                atc_pkg::WAVE_CTC: begin
                    next_counter_value = at_top ? atc_pkg::CNT_BOTTOM : counter_value + 8'h01;
                    next_count_down = 1'b0;
                    if (counter_value == atc_pkg::CNT_MAX) begin
                        next_overflow_flag = 1'b1;
                    end
                end
                default: begin
                    next_counter_value = counter_value + 8'h01;
                    next_count_down = 1'b0;
                    if (counter_value == atc_pkg::CNT_MAX) begin
                        next_overflow_flag = 1'b1;
                    end
                end
            endcase

            // waveform generator
            if (com != 2'h0) begin
                case (wave)
                    atc_pkg::WAVE_FAST: begin
                        if (com[1]) begin
                            if (cmp_act == atc_pkg::CNT_MAX) begin
                                if (at_top) begin
                                    next_oc = !com[0]; // R4
                                end
                            end else if (do_match) begin
                                next_oc = com[0]; // R3
                            end else if (counter_value == atc_pkg::CNT_MAX) begin
                                next_oc = !com[0]; // R3
                            end
                        end
                    end
                    atc_pkg::WAVE_PHASE: begin
                        if (com[1]) begin
                            if (cmp_act == atc_pkg::CNT_MAX) begin
                                if (at_top) begin
                                    next_oc = !com[0]; // R4
                                end
                            end else if (do_match) begin
                                next_oc = count_down ? !com[0] : com[0]; // R5
                            end
                        end
                    end
                    default: begin
                        if (do_match) begin
                            case (com)
                                2'h1: next_oc = !oc; // R2
                                2'h2: next_oc = 1'b0; // R2
                                default: next_oc = 1'b1; // R2
                            endcase
                        end
                    end
                endcase
            end
        end

        // force strobe: non-PWM only, no flag, no counter clear
        force_cmp = wr_ctl && reg_wdata[atc_pkg::CTL_FORCE] && !pwm;
        if (force_cmp) begin
            case (reg_wdata[atc_pkg::CTL_COM_HI:atc_pkg::CTL_COM_LO])
                2'h0: next_oc = oc;
                2'h1: next_oc = !oc;
                2'h2: next_oc = 1'b0;
                default: next_oc = 1'b1;
            endcase
        end

        // loads: direct in sync mode, on transfer in async mode
        if (async_clock_select ? xfer[atc_pkg::SLOT_CNT] : wr_cnt) begin
            next_counter_value = async_clock_select ? cnt_tmp : reg_wdata; // R7 R19
            next_match_block = 1'b1; // R8
        end
        if (async_clock_select ? xfer[atc_pkg::SLOT_CMP] : wr_cmp) begin
            next_cmp_act = async_clock_select ? cmp_tmp : reg_wdata; // R19
        end
        if (async_clock_select ? xfer[atc_pkg::SLOT_CTL] : wr_ctl) begin
            next_ctl_act = async_clock_select ? ctl_tmp : {1'b0, reg_wdata[6:0]}; // R19
        end

        // flags: a set in the same cycle as a clear wins, except an overflow while the overflow flag is already set
        next_compare_flag = compare_flag;
        if ((wr_flags && reg_wdata[atc_pkg::FL_COMPARE]) || vector_ack) begin
            next_compare_flag = 1'b0; // R20
        end
        if (do_match) begin
            next_compare_flag = 1'b1; // R20 R9
        end
        if (wr_flags && reg_wdata[atc_pkg::FL_OVERFLOW] && !(next_overflow_flag && !overflow_flag)) begin
            next_overflow_flag = 1'b0;
        end
    end

    // read mux; counter, async status and flags live, control and compare from temporaries
    always_comb begin
        next_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                atc_pkg::ADDR_CONTROL: next_rdata = ctl_tmp; // R18
                atc_pkg::ADDR_COUNTER: next_rdata = counter_value; // R18 R7
                atc_pkg::ADDR_COMPARE: next_rdata = cmp_tmp; // R18
                atc_pkg::ADDR_ASYNC: next_rdata = {3'h0, ext_clock_enable, async_clock_select, busy[atc_pkg::SLOT_CNT],
                    busy[atc_pkg::SLOT_CMP], busy[atc_pkg::SLOT_CTL]};
                atc_pkg::ADDR_FLAGS: next_rdata = {6'h00, compare_flag, overflow_flag};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // pin mux; direction bit still gates the driver
    assign compare_output_pin = oc;
    assign pin_out = (com != 2'h0) ? oc : port_out; // R1
    assign pin_oe_n = !port_dir; // R1

    // state registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_tmp <= atc_pkg::CTL_RESET;
            cmp_tmp <= 8'h00;
            cnt_tmp <= 8'h00;
            ctl_act <= atc_pkg::CTL_RESET;
            cmp_act <= 8'h00;
            counter_value <= 8'h00;
            ext_clock_enable <= 1'b0;
            async_clock_select <= 1'b0;
            busy <= '0;
            for (int i = 0; i < SLOTS_W; i++) begin
                edges[i] <= 2'h0;
            end
            count_down <= 1'b0;
            match_block <= 1'b0;
            oc <= 1'b0;
            compare_flag <= 1'b0;
            overflow_flag <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            ctl_tmp <= next_ctl_tmp;
            cmp_tmp <= next_cmp_tmp;
            cnt_tmp <= next_cnt_tmp;
            ctl_act <= next_ctl_act;
            cmp_act <= next_cmp_act;
            counter_value <= next_counter_value;
            ext_clock_enable <= next_ext_clock_enable;
            async_clock_select <= next_async_clock_select;
            busy <= next_busy;
            for (int i = 0; i < SLOTS_W; i++) begin
                edges[i] <= next_edges[i];
            end
            count_down <= next_count_down;
            match_block <= next_match_block;
            oc <= next_oc;
            compare_flag <= next_compare_flag;
            overflow_flag <= next_overflow_flag;
            reg_rdata <= next_rdata;
        end
    end
endmodule

// ### atc_timer_checker.sv
// Purpose: port-level assertions for atc_timer
// Assumes: one clk_sys domain, asynchronous active-high reset
// Notes: shadows async_status writes to know the clock mode
module atc_timer_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic port_out,
    input wire logic port_dir,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    input wire logic compare_output_pin,
    input wire logic compare_flag,
    input wire logic ext_clock_buf_en,
    input wire logic crystal_osc_en
);
    logic [1:0] mode_q;
    logic [1:0] next_mode_q;

    // bit 1 external clock enable, bit 0 async select
    always_comb begin
        next_mode_q = mode_q;
        if (reg_wr && reg_addr == atc_pkg::ADDR_ASYNC) begin
            next_mode_q = {reg_wdata[atc_pkg::AS_EXT_CLK], reg_wdata[atc_pkg::AS_ASYNC]};
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_q <= 2'h0;
        end else begin
            mode_q <= next_mode_q;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    oe_follow_a: assert property (pin_oe_n == !port_dir) else $error("pin enable wrong");
    pin_source_a: assert property (pin_out == compare_output_pin || pin_out == port_out)
        else $error("pin source wrong");
    ext_buf_a: assert property (ext_clock_buf_en == (mode_q[0] && mode_q[1])) else $error("ext buf");
    crystal_a: assert property (crystal_osc_en == (mode_q[0] && !mode_q[1])) else $error("crystal");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    unmapped_rd_a: assert property (reg_rd && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
        else $error("unmapped read");
    force_zero_a: assert property (reg_rd && reg_addr == atc_pkg::ADDR_CONTROL |=> !reg_rdata[7])
        else $error("force bit read");
    cnt_busy_a: assert property (reg_wr && reg_addr == atc_pkg::ADDR_COUNTER ##2 reg_rd
        && reg_addr == atc_pkg::ADDR_ASYNC |=> reg_rdata[atc_pkg::AS_CNT_BUSY] == mode_q[0]) else $error("cnt busy");
    cmp_busy_a: assert property (reg_wr && reg_addr == atc_pkg::ADDR_COMPARE ##2 reg_rd
        && reg_addr == atc_pkg::ADDR_ASYNC |=> reg_rdata[atc_pkg::AS_CMP_BUSY] == mode_q[0]) else $error("cmp busy");

    cover property (reg_wr && reg_addr == atc_pkg::ADDR_COUNTER && mode_q[0]);
    cover property ($rose(compare_flag));
    cover property ($rose(compare_output_pin));
endmodule

bind atc_timer atc_timer_checker atc_timer_checker_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_out(port_out),
    .port_dir(port_dir), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .compare_output_pin(compare_output_pin),
    .compare_flag(compare_flag), .ext_clock_buf_en(ext_clock_buf_en), .crystal_osc_en(crystal_osc_en));

// ### atc_osc_model.sv
// Purpose: clock source standing on the oscillator pin
// Assumes: period far above four system clocks
// Notes: held low while run is low, like a stopped source
module atc_osc_model #(
    parameter int HALF_NS = 100
) (
    input wire logic run,
    output logic timer_osc_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial timer_osc_in = 1'b0;
    // unrelated in phase to clk_sys
    always begin
        #(HALF_NS);
        timer_osc_in = run ? !timer_osc_in : 1'b0;
    end
endmodule

// ### tb_top.sv
// Purpose: self-checking bench for atc_timer
// Assumes: 50 MHz clock, oscillator model at 5 MHz
// Notes: rows cover waveform shapes, hand tests the rest
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [7:0] ctl; logic [7:0] cmp; int exp; int tol;} atc_row_s;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic vector_ack = 1'b0;
    logic port_out = 1'b0;
    logic port_dir = 1'b1;
    logic [7:0] reg_rdata, v, a;
    logic osc, pin_out, pin_oe_n, cmp_pin, cmp_flag, ext_en, xtal_en, ovf;
    localparam logic [2:0] A_CTL = atc_pkg::ADDR_CONTROL, A_CNT = atc_pkg::ADDR_COUNTER;
    localparam logic [2:0] A_CMP = atc_pkg::ADDR_COMPARE, A_AS = atc_pkg::ADDR_ASYNC, A_FL = atc_pkg::ADDR_FLAGS;
    int error_cnt = 0;
    int checks = 0;
    int i, n;
    // control, compare, high time in cycles, slack
    atc_row_s rows[11] = '{'{8'h19, 8'h03, 4, 1}, '{8'h1a, 8'h03, 32, 1}, '{8'h1b, 8'h03, 128, 1},
        '{8'h1c, 8'h03, 256, 1}, '{8'h1d, 8'h03, 512, 1}, '{8'h1e, 8'h03, 1024, 1}, '{8'h1f, 8'h03, 4096, 1},
        '{8'h69, 8'h40, 65, 2}, '{8'h79, 8'h40, 191, 2}, '{8'h61, 8'h40, 128, 3}, '{8'h71, 8'h40, 382, 3}};

    atc_osc_model atc_osc_model_inst (.run(1'b1), .timer_osc_in(osc));
    atc_timer atc_timer_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_osc_in(osc), .vector_ack(vector_ack),
        .port_out(port_out), .port_dir(port_dir), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .compare_output_pin(cmp_pin), .compare_flag(cmp_flag), .overflow_flag(ovf),
        .ext_clock_buf_en(ext_en), .crystal_osc_en(xtal_en));

    always #10 clk_sys = !clk_sys;

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // strobes end low, so calls may follow at once
    task automatic wr(input logic [2:0] ad, input logic [7:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [2:0] ad, output logic [7:0] d);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic wait_pin(input logic lvl);
        int k;
        for (k = 0; k < 20000 && pin_out !== lvl; k++) @(posedge clk_sys);
        if (k == 20000) begin
            error_cnt++;
            finish_test();
        end
    endtask
    task automatic high_time(output int h);
        wait_pin(1'b0);
        wait_pin(1'b1);
        for (h = 0; h < 20000 && pin_out === 1'b1; h++) @(posedge clk_sys);
        if (h == 20000) error_cnt++;
    endtask
    // busy bits poll, bounded
    task automatic poll_idle(output int p);
        logic [7:0] s;
        p = 0;
        do begin
            rd(A_AS, s);
            p++;
        end while (s[2:0] !== 3'h0 && p < 100);
        if (p == 100) begin
            error_cnt++;
            finish_test();
        end
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[r]) begin
            wr(A_CTL, 8'h00);
            wr(A_CNT, 8'h00);
            wr(A_CMP, rows[r].cmp);
            wr(A_CTL, rows[r].ctl);
            high_time(n);
            check("high time", n >= rows[r].exp - rows[r].tol && n <= rows[r].exp + rows[r].tol, 1);
            $display("row %0d high %0d", r, n);
        end
        // direct access in sync mode, never busy
        wr(A_CTL, 8'h00);
        wr(A_CNT, 8'h5a);
        rd(A_AS, v);
        check("sync busy", v[2:0], 3'h0);
        rd(A_CNT, a);
        check("counter", a, 8'h5a);
        for (i = 2; i < 4; i++) begin
            wr(A_CTL, 8'h80 | 8'(i << 4));
            @(posedge clk_sys);
            check("forced level", cmp_pin, i[0]);
        end
        $display("test direct done");
        // counter write hides the next match, flag comes a wrap later
        wr(A_CTL, 8'h00);
        wr(A_FL, 8'h03);
        wr(A_CMP, 8'h10);
        wr(A_CNT, 8'h80);
        wr(A_CTL, 8'h11);
        wr(A_CNT, 8'h10);
        for (i = 0; i < 300 && cmp_flag !== 1'b1; i++) @(posedge clk_sys);
        check("match gap", i >= 250 && i <= 262, 1);
        check("overflow", ovf, 1'b1);
        vector_ack <= 1'b1;
        @(posedge clk_sys);
        vector_ack <= 1'b0;
        @(posedge clk_sys);
        check("ack clear", cmp_flag, 1'b0);
        for (i = 0; i < 300 && cmp_flag !== 1'b1; i++) @(posedge clk_sys);
        check("match again", cmp_flag, 1'b1);
        wr(A_FL, 8'h02);
        check("write clear", cmp_flag, 1'b0);
        $display("test match done");
        // compare at top in both pwm modes gives a flat level
        foreach (rows[r]) if (r == 7 || r == 9) begin
            wr(A_CMP, 8'hff);
            wr(A_CTL, rows[r].ctl);
            repeat (600) @(posedge clk_sys);
            for (n = 0; n < 600 && pin_out === 1'b1; n++) @(posedge clk_sys);
            check("flat top", n == 600, 1);
        end
        // stopped counter holds
        wr(A_CTL, 8'h10);
        rd(A_CNT, a);
        repeat (50) @(posedge clk_sys);
        rd(A_CNT, v);
        check("stopped", v, a);
        // async: clock enable first, then select
        wr(A_AS, 8'h10);
        wr(A_AS, 8'h18);
        check("ext buf", {ext_en, xtal_en}, 2'b10);
        wr(A_CNT, 8'h33);
        rd(A_AS, v);
        check("cnt busy", v[2], 1'b1);
        wr(A_CMP, 8'h44);
        rd(A_CMP, v);
        check("cmp temp", v, 8'h44);
        wr(A_CTL, 8'h12);
        rd(A_AS, v);
        check("busy", v[1:0], 2'h3);
        rd(A_CTL, v);
        check("ctl temp", v, 8'h12);
        poll_idle(n);
        check("two edges", n >= 3, 1);
        rd(A_CNT, v);
        check("cnt loaded", v, 8'h33);
        rd(A_CNT, a);
        repeat (200) @(posedge clk_sys);
        rd(A_CNT, v);
        check("osc count", 8'(v - a) >= 8'd2 && 8'(v - a) <= 8'd4, 1);
        wr(A_AS, 8'h08);
        check("crystal", {ext_en, xtal_en}, 2'b01);
        $display("test async done");
        // reset in mid-run
        rst <= 1'b1;
        port_out <= 1'b1;
        port_dir <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check("reset pin", {pin_out, pin_oe_n, xtal_en}, 3'h6);
        for (i = 0; i < 6; i++) begin
            rd(i[2:0], v);
            check("reset read", v, 8'h00);
        end
        $display("test reset done");
        finish_test();
    end
endmodule
